// ==== rtl/ncid_consts.svh ====
`ifndef NCID_CONSTS_SVH
`define NCID_CONSTS_SVH
// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define NCID_DIV_SLOW    5'h1f
`define NCID_WDT_DEF     14'h3fff
`define NCID_IRQ_VEC     12'h008
`define NCID_CTL_RST     8'h00
`define NCID_CTL_WDT     3'h7
`define NCID_SEL_GATE    4'h8
// ----------------------------------------
// second byte of the 0x2c group
// ----------------------------------------
`define NCID_OPB_CI      4'h4
`define NCID_OPB_SET     4'h5
`define NCID_OPB_CLR     4'h6
`endif

// ==== rtl/ncid_core.sv ====
// Summary of operation
// - load_ptr_zero_imm clears high pointer nibble, loads low nibble, one cycle.
// - load_ptr_high_imm loads high pointer nibble, low nibble kept, one cycle.
// - accumulator swaps with work_reg_a 0..3 of the selected bank.
// - pointer high nibble swaps with work_reg_h 0..1, flags untouched.
// - pointer low nibble swaps with work_reg_l 0..1, flags untouched.
// - sixteen user flags; flag_bit_clear sets zero from the holding nibble.
// - long_jump loads 11 bits in bank; preceding bank change flips top bit.
// - page_jump_indexed loads low eight pc bits from aux and accumulator.
// - subr_zero_page pushes pc+1, clears pc bits, loads bits 5..2.
// - zero-bank call pushes pc+2, clears bit 11, loads bits 10..0.
// - irq_return pops pc and restores flags; plain return pops pc only.
// - accumulator bit branch loads low pc byte when bit set, inverse when clear.
// - memory bit branch tests addressed data nibble bit the same way.
// - port bit branch tests addressed port or pseudo_port bit the same way.
// - carry and zero branches load low pc byte on flag set or clear.
// - user flag branch picks one of sixteen flags by four opcode bits.
// - port_bit_set and port_bit_clear take two cycles, trash aux; clear sets zero.
// - ctrl_bit_set and ctrl_bit_clear take selectors 0..8; clear sets zero.
// - runs of acc_load_imm or acc_zero act as no-op after the first.
// - compare sets carry and zero per greater, equal or smaller operand.
// - clock divider leaves reset at 1/1 or 1/32 by factory option.
// - watchdog raises a request; software must clear its flag in time.
`timescale 1ns/10ps
`include "ncid_consts.svh"
module ncid_core
   import ncid_pkg::*;
#(
   parameter bit          DIV_ONE   = 1'b0,
   parameter bit          WDT_EN    = 1'b1,
   parameter logic [13:0] WDT_LIMIT = `NCID_WDT_DEF
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst,
   input  wire logic [7:0]    i_prog_byte,
   input  wire logic [3:0]    i_mem_nibble,
   input  wire logic [3:0]    i_port_nibble,
   input  wire logic          i_irq_req,
   output logic [11:0]        o_pc,
   output logic [7:0]         o_dp,
   output ncid_port_wr_s      o_port_wr,
   output ncid_alu_s          o_alu,
   output logic [7:0]         o_ctl,
   output logic               o_gate,
   output logic               o_wdt_irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   ncid_state_e state;
   logic [11:0] pc;
   logic [3:0]  pointer_high_nibble, pointer_low_nibble;
   logic [3:0]  accumulator, aux;
   logic        carry_flag, zero_flag, saved_carry, saved_zero;
   logic [1:0]  reg_bank_select;
   logic [15:0] user_flag_bits;
   logic [7:0]  control_register;
   logic        master_irq_gate;
   logic [7:0]  op;
   logic        bank_flip, last_li;
   logic [3:0]  work [32];
   logic [11:0] stk [8];
   logic [2:0]  sp;
   logic [4:0]  div_cnt;
   logic        div_one;
   logic [13:0] wdt_cnt;
   ncid_port_wr_s port_wr;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire        tick     = div_one | (div_cnt == `NCID_DIV_SLOW);
   wire [7:0]  cur      = (state == NCID_FETCH) ? i_prog_byte : op;
   wire [7:0]  b2       = i_prog_byte;
   wire        two_byte = (cur[7:3] == 5'b01101) | (cur[7:3] == 5'b10101) |
                          (cur[7] == 1'b0 && cur[5:4] == 2'b11) |
                          (cur[7] && cur[5:4] == 2'b01) | (cur == 8'h2c);
   wire        port_op  = (cur[7:6] == 2'b00) && (cur[4:2] == 3'b001);
   wire        do_irq   = (state == NCID_FETCH) && i_irq_req && master_irq_gate;
   wire        exec     = tick && !do_irq && ((state == NCID_FETCH && !two_byte && !port_op) ||
                          state != NCID_FETCH);
   wire [4:0]  widx_a   = {reg_bank_select, 1'b0, cur[3:2]};
   wire [4:0]  widx_h   = {reg_bank_select, 2'b10, cur[2]};
   wire [4:0]  widx_l   = {reg_bank_select, 2'b11, cur[2]};
   wire [3:0]  uf_nib   = user_flag_bits[{cur[3:2], 2'b00} +: 4];
   wire [3:0]  uf_clr   = uf_nib & ~(4'h1 << cur[1:0]);
   wire [3:0]  pt_set   = i_port_nibble | (4'h1 << cur[1:0]);
   wire [3:0]  pt_clr   = i_port_nibble & ~(4'h1 << cur[1:0]);
   wire        grp11    = (cur[3:2] == 2'b11);
   wire        br_bit   = cur[7] ? user_flag_bits[cur[3:0]] :
                          grp11 ? (cur[6] ? zero_flag : carry_flag) :
                          (cur[3:2] == 2'b00) ? accumulator[cur[1:0]] :
                          (cur[3:2] == 2'b01) ? i_mem_nibble[cur[1:0]] :
                          i_port_nibble[cur[1:0]];
   wire        br_inv   = (!cur[7] && grp11) ? cur[0] : ~cur[6];
   wire        taken    = br_bit ^ br_inv;
   wire [3:0]  cmp_src  = (state == NCID_SECOND) ? b2[3:0] : i_mem_nibble;
   wire        ctl_sel8 = (b2[3:0] == `NCID_SEL_GATE);
   wire        ctl_ok   = (b2[3:0] <= `NCID_SEL_GATE);
   wire [7:0]  ctl_clr  = control_register & ~(8'h01 << b2[2:0]);
   wire        wdt_hit  = WDT_EN && tick && (wdt_cnt == WDT_LIMIT);
   wire [11:0] pc_inc   = pc + 12'h001;
   // ----------------------------------------
   // clock divider and watchdog
   // ----------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         div_one <= DIV_ONE;
         div_cnt <= 5'h00;
         wdt_cnt <= 14'h0000;
      end else begin
         div_cnt <= div_cnt + 5'h01;
         wdt_cnt <= (!tick || !WDT_EN) ? wdt_cnt : wdt_hit ? 14'h0000 : wdt_cnt + 14'h0001;
      end
   end
   // ----------------------------------------
   // sequencer and execution
   // ----------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= NCID_FETCH;
         pc <= 12'h000;
         {pointer_high_nibble, pointer_low_nibble} <= 8'h00;
         {accumulator, aux} <= 8'h00;
         {carry_flag, zero_flag, saved_carry, saved_zero} <= 4'h0;
         reg_bank_select <= 2'b00;
         user_flag_bits <= 16'h0000;
         control_register <= `NCID_CTL_RST;
         master_irq_gate <= 1'b0;
         op <= 8'h00;
         {bank_flip, last_li} <= 2'b00;
         sp <= 3'h0;
         port_wr <= '0;
         for (int i = 0; i < 32; i++) begin
            work[i] <= 4'h0;
         end
      end else begin
         port_wr.wr <= 1'b0;
         if (wdt_hit) begin
            control_register[`NCID_CTL_WDT] <= 1'b1;
         end
         if (do_irq && tick) begin
            stk[sp] <= pc;
            sp <= sp + 3'h1;
            saved_carry <= carry_flag;
            saved_zero <= zero_flag;
            master_irq_gate <= 1'b0;
            pc <= `NCID_IRQ_VEC;
         end else if (tick && state == NCID_FETCH && (two_byte || port_op)) begin
            op <= i_prog_byte;
            pc <= pc_inc;
            state <= two_byte ? NCID_SECOND : NCID_EXTRA;
         end else if (exec) begin
            state <= NCID_FETCH;
            last_li <= 1'b0;
            if (state == NCID_FETCH) begin
               pc <= pc_inc;
            end
            if (cur[7:4] != 4'hf || cur[3:0] != 4'hd) begin
               bank_flip <= 1'b0;
            end
            if (state == NCID_EXTRA) begin
               port_wr.wr <= 1'b1;
               port_wr.addr <= {pointer_high_nibble, pointer_low_nibble};
               port_wr.data <= cur[5] ? pt_clr : pt_set;
               aux <= i_port_nibble;
               if (cur[5]) begin
                  zero_flag <= (pt_clr == 4'h0);
               end
            end else if (state == NCID_SECOND) begin
               pc <= pc_inc;
               casez (cur)
                  8'b0110_1???: begin
                     pc <= {pc[11] ^ bank_flip, cur[2:0], b2};
                  end
                  8'b1010_1???: begin
                     stk[sp] <= pc_inc;
                     sp <= sp + 3'h1;
                     pc <= {1'b0, cur[2:0], b2};
                  end
                  8'h2c: begin
                     if (b2[7:4] == `NCID_OPB_CI) begin
                        carry_flag <= (cmp_src <= accumulator);
                        zero_flag <= (cmp_src == accumulator);
                     end else if (b2[7:4] == `NCID_OPB_SET && ctl_ok) begin
                        if (ctl_sel8) begin
                           master_irq_gate <= 1'b1;
                        end else begin
                           control_register[b2[2:0]] <= 1'b1;
                        end
                     end else if (b2[7:4] == `NCID_OPB_CLR && ctl_ok) begin
                        if (ctl_sel8) begin
                           master_irq_gate <= 1'b0;
                           zero_flag <= 1'b1;
                        end else begin
                           control_register[b2[2:0]] <= wdt_hit && b2[2:0] == `NCID_CTL_WDT;
                           zero_flag <= (ctl_clr == 8'h00);
                        end
                     end
                  end
                  default: begin
                     if (taken) begin
                        pc <= {pc[11:8], b2};
                     end
                  end
               endcase
            end else begin
               casez (cur)
                  8'b1000_????: begin
                     pointer_high_nibble <= 4'h0;
                     pointer_low_nibble <= cur[3:0];
                  end
                  8'b0100_????: begin
                     pointer_high_nibble <= cur[3:0];
                  end
                  8'b1110_??00: begin
                     accumulator <= work[widx_a];
                     work[widx_a] <= accumulator;
                  end
                  8'b1111_1?00: begin
                     pointer_high_nibble <= work[widx_h];
                     work[widx_h] <= pointer_high_nibble;
                  end
                  8'b1111_0?00: begin
                     pointer_low_nibble <= work[widx_l];
                     work[widx_l] <= pointer_low_nibble;
                  end
                  8'hee, 8'hef: begin
                     pointer_low_nibble <= cur[0] ? pointer_low_nibble - 4'h1
                                                  : pointer_low_nibble + 4'h1;
                     zero_flag <= cur[0] ? (pointer_low_nibble == 4'h1)
                                         : (pointer_low_nibble == 4'hf);
                  end
                  8'hf7: pointer_low_nibble <= accumulator;
                  8'he9: begin
                     accumulator <= pointer_low_nibble;
                     zero_flag <= (pointer_low_nibble == 4'h0);
                  end
                  8'h03: begin
                     aux <= accumulator;
                  end
                  8'h23: begin
                     accumulator <= pointer_high_nibble;
                     pointer_high_nibble <= accumulator;
                  end
                  8'b0110_01??: reg_bank_select <= cur[1:0];
                  8'b0101_????: user_flag_bits[cur[3:0]] <= 1'b1;
                  8'b0001_????: begin
                     user_flag_bits[cur[3:0]] <= 1'b0;
                     zero_flag <= (uf_clr == 4'h0);
                  end
                  8'hfa: pc <= {pc[11:8], aux, accumulator};
                  8'b1011_????: begin
                     stk[sp] <= pc_inc;
                     sp <= sp + 3'h1;
                     pc <= {6'h00, cur[3:0], 2'b00};
                  end
                  8'h62, 8'h22: begin
                     pc <= stk[sp - 3'h1];
                     sp <= sp - 3'h1;
                     if (!cur[6]) begin
                        carry_flag <= saved_carry;
                        zero_flag <= saved_zero;
                     end
                  end
                  8'hfd: bank_flip <= ~bank_flip;
                  8'b1100_????: begin
                     last_li <= 1'b1;
                     if (!last_li) begin
                        accumulator <= cur[3:0];
                        zero_flag <= (cur[3:0] == 4'h0);
                     end
                  end
                  8'hfb: begin
                     carry_flag <= (cmp_src <= accumulator);
                     zero_flag <= (cmp_src == accumulator);
                  end
                  default: ;
               endcase
            end
         end
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_wdt_irq <= 1'b0;
      end else begin
         o_wdt_irq <= control_register[`NCID_CTL_WDT] & master_irq_gate;
      end
   end
   assign o_pc = pc;
   assign o_dp = {pointer_high_nibble, pointer_low_nibble};
   assign o_port_wr = port_wr;
   assign o_alu = '{acc: accumulator, carry: carry_flag, zero: zero_flag};
   assign o_ctl = control_register;
   assign o_gate = master_irq_gate;
endmodule // ncid_core

// ==== rtl/ncid_pkg.sv ====
package ncid_pkg;
   typedef enum logic [1:0] {
      NCID_FETCH,
      NCID_SECOND,
      NCID_EXTRA
   } ncid_state_e;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [3:0] data;
   } ncid_port_wr_s;
   typedef struct packed {
      logic [3:0] acc;
      logic       carry;
      logic       zero;
   } ncid_alu_s;
endpackage

// ==== tb/ncid_core_assertions.sv ====
`timescale 1ns/10ps
// ------------------------
// port checker
// ------------------------
module ncid_core_assertions
   import ncid_pkg::*;
#(
   parameter bit DIV_ONE = 1'b0
) (
   input wire logic          i_ref_clk,
   input wire logic          i_rst,
   input wire logic [7:0]    i_prog_byte,
   input wire logic          i_irq_req,
   input wire logic [11:0]   o_pc,
   input wire logic [7:0]    o_dp,
   input wire ncid_port_wr_s o_port_wr,
   input wire ncid_alu_s     o_alu,
   input wire logic [7:0]    o_ctl,
   input wire logic          o_gate,
   input wire logic          o_wdt_irq
);
   logic       first;
   logic [2:0] prev_hi;
   wire  [3:0] byte_lo = i_prog_byte[3:0];
   wire  [3:0] acc     = o_alu.acc;
   wire        wdt_src = o_ctl[7] & o_gate;
   wire        two_b   = i_prog_byte[7:3] == 5'b01101 || i_prog_byte[7:3] == 5'b10101
                         || i_prog_byte[5:4] == {~i_prog_byte[7], 1'b1} || i_prog_byte == 8'h2c;
   wire        port_b  = i_prog_byte[7:2] == 6'h01 || i_prog_byte[7:2] == 6'h09;
   wire        fet     = first && !(i_irq_req && o_gate);
   // tracks which cycles carry an opcode (one tick per edge)
   always_ff @(posedge i_ref_clk) begin
      first   <= i_rst || !fet || !(two_b || port_b);
      prev_hi <= i_prog_byte[2:0];
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst || !DIV_ONE);
   AST_LOAD_ZERO: assert property (fet && i_prog_byte[7:4] == 4'h8 |=>
      o_dp == {4'h0, $past(byte_lo)}) else $error("pointer load wrong");
   AST_LONG_JUMP: assert property (fet && i_prog_byte[7:3] == 5'b01101 ##1 1'b1 |=>
      o_pc[10:0] == {$past(prev_hi), $past(i_prog_byte)}) else $error("jump target wrong");
   AST_PAGE_CALL: assert property (fet && i_prog_byte[7:4] == 4'hb |=>
      o_pc == {6'h00, $past(byte_lo), 2'h0}) else $error("page call target wrong");
   AST_BANK_CALL: assert property (fet && i_prog_byte[7:3] == 5'b10101 ##1 1'b1 |=>
      o_pc == {1'b0, $past(prev_hi), $past(i_prog_byte)}) else $error("bank call wrong");
   AST_COMPARE: assert property (fet && i_prog_byte == 8'h2c ##1 i_prog_byte[7:4] == 4'h4 |=>
      o_alu.carry == ($past(byte_lo) <= $past(acc)) && o_alu.zero == ($past(byte_lo) == $past(acc)))
      else $error("compare flags wrong");
   AST_PORT_WRITE: assert property (fet && port_b |->
      ##1 !o_port_wr.wr ##1 o_port_wr.wr && o_port_wr.addr == o_dp) else $error("port write wrong");
   AST_WDT_FOLLOW: assert property (1'b1 |=> o_wdt_irq == $past(wdt_src))
      else $error("watchdog request wrong");
   AST_LOAD_RUN: assert property (fet && i_prog_byte[7:4] == 4'hc ##1
      fet && i_prog_byte[7:4] == 4'hc |=> acc == $past(acc)) else $error("load run not idle");
endmodule // ncid_core_assertions

// ==== tb/ncid_prog_mem.sv ====
`timescale 1ns/10ps
// ------------------------
// program memory model
// ------------------------
module ncid_prog_mem (
   input  wire logic [11:0] i_addr,
   output logic [7:0]       o_byte
);
   logic [7:0] mem [4096];
   initial begin
      for (int a = 0; a < 4096; a++) begin
         mem[a] = 8'h00;
      end
   end
   // combinational read, no wait states
   assign o_byte = mem[i_addr];
endmodule // ncid_prog_mem

// ==== tb/nibble_cpu_instruction_decode_tb.sv ====
`timescale 1ns/10ps
module nibble_cpu_instruction_decode_tb;
   import ncid_pkg::*;
   logic          i_ref_clk, i_rst, i_irq_req, o_gate, o_wdt_irq, ec, ez;
   logic [3:0]    i_mem_nibble, i_port_nibble, eacc, n, k, v;
   logic [7:0]    prog_byte, o_dp, o_ctl, edp;
   logic [11:0]   o_pc, epc, ret;
   logic [15:0]   flg;
   logic [10:0]   a;
   logic [1:0]    fm;
   ncid_port_wr_s o_port_wr;
   ncid_alu_s     o_alu;
   integer        seed, miscompares, cmp_count, i;
   wire  [8:0]    ctl_all = {o_gate, o_ctl};
   logic [11:0]   slow_pc;
   integer        edges;
   always #10 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) edges <= i_rst ? 0 : edges + 1;
   ncid_core #(.DIV_ONE(1'b1), .WDT_EN(1'b1), .WDT_LIMIT(14'h0010)) uut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_prog_byte(prog_byte),
      .i_mem_nibble(i_mem_nibble), .i_port_nibble(i_port_nibble), .i_irq_req(i_irq_req),
      .o_pc(o_pc), .o_dp(o_dp), .o_port_wr(o_port_wr), .o_alu(o_alu), .o_ctl(o_ctl),
      .o_gate(o_gate), .o_wdt_irq(o_wdt_irq));
   ncid_prog_mem pm (.i_addr(o_pc), .o_byte(prog_byte));
   ncid_core #(.DIV_ONE(1'b0), .WDT_EN(1'b1), .WDT_LIMIT(14'h0010)) uut_slow (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_prog_byte(8'h00),
      .i_mem_nibble(4'h0), .i_port_nibble(4'h0), .i_irq_req(1'b0),
      .o_pc(slow_pc), .o_dp(), .o_port_wr(), .o_alu(), .o_ctl(),
      .o_gate(), .o_wdt_irq());
   // ------------------------
   // shared tasks
   // ------------------------
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic run(input logic [7:0] b0, input logic [7:0] b1, input int t,
                      input logic [11:0] npc);
      pm.mem[epc] = b0;
      pm.mem[epc + 12'h001] = b1;
      repeat (t) @(posedge i_ref_clk);
      #1;
      epc = npc;
      chk(o_pc === epc, "pc");
   endtask
   task automatic li(input logic [3:0] val);
      run(8'h00, 8'h00, 1, epc + 12'h001);
      run({4'hc, val}, 8'h00, 1, epc + 12'h001);
      eacc = val;
      ez = (val == 4'h0);
   endtask
   task automatic br(input logic [7:0] op, input logic take);
      logic [7:0] tg;
      logic [11:0] nx;
      tg = $random(seed);
      nx = epc + 12'h001;
      run(op, tg, 2, take ? {nx[11:8], tg} : epc + 12'h002);
   endtask
   task automatic cmp_imm(input logic [3:0] kv);
      run(8'h2c, {4'h4, kv}, 2, epc + 12'h002);
      ec = (kv <= eacc);
      ez = (kv == eacc);
      chk(o_alu.carry === ec && o_alu.zero === ez, "compare");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ------------------------
   // main sequence
   // ------------------------
   initial begin
      i_ref_clk = 1'b0;
      i_rst = 1'b1;
      i_irq_req = 1'b0;
      i_mem_nibble = 4'h0;
      i_port_nibble = 4'h0;
      seed = 17;
      miscompares = 0;
      cmp_count = 0;
      epc = 12'h000;
      flg = 16'h0000;
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk(o_pc === 12'h000 && o_dp === 8'h00 && o_ctl === 8'h00 && o_gate === 1'b0, "reset");
      i_rst = 1'b0;
      repeat (31) @(posedge i_ref_clk);
      #1;
      chk(slow_pc === 12'h000, "slow divider hold");
      @(posedge i_ref_clk);
      #1;
      chk(slow_pc === 12'h001, "slow divider tick");
      epc = o_pc;
      n = $random(seed);
      run({4'h8, n}, 8'h00, 1, epc + 12'h001);
      edp = {4'h0, n};
      chk(o_dp === edp, "ptr low");
      n = $random(seed);
      run({4'h4, n}, 8'h00, 1, epc + 12'h001);
      edp[7:4] = n;
      chk(o_dp === edp, "ptr high");
      li(4'h0);
      run(8'hc9, 8'h00, 1, epc + 12'h001);
      chk(o_alu.acc === eacc && o_alu.zero === ez, "load run");
      for (i = 0; i < 16; i++) begin
         run({4'h1, i[3:0]}, 8'h00, 1, epc + 12'h001);
      end
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         li(v);
         k = $random(seed);
         if (i < 2) k = v;
         cmp_imm(k);
         n = $random(seed);
         br({1'b0, n[1], 5'h1f, n[0]}, (n[1] ? ez : ec) != n[0]);
      end
      for (i = 0; i < 12; i++) begin
         n = $random(seed);
         i_mem_nibble = $random(seed);
         i_port_nibble = $random(seed);
         fm = 2'(i % 3);
         k = (fm == 2'd0) ? eacc : (fm == 2'd1) ? i_mem_nibble : i_port_nibble;
         br({1'b0, n[2], 2'b11, fm, n[1:0]}, k[n[1:0]] == n[2]);
      end
      for (i = 0; i < 6; i++) begin
         n = $random(seed);
         run({4'h5, n}, 8'h00, 1, epc + 12'h001);
         flg[n] = 1'b1;
         br({4'hd, n}, 1'b1);
         br({4'h9, n}, 1'b0);
         n[0] = n[0] ^ i[0];
         run({4'h1, n}, 8'h00, 1, epc + 12'h001);
         flg[n] = 1'b0;
         chk(o_alu.zero === (flg[{n[3:2], 2'b00} +: 4] == 4'h0), "flag zero");
      end
      v = $random(seed);
      li(v);
      run(8'h03, 8'h00, 1, epc + 12'h001);
      k = $random(seed);
      li(k);
      run(8'hfa, 8'h00, 1, {epc[11:8], v, k});
      for (i = 0; i < 4; i++) begin
         a = $random(seed);
         if (i[0]) run(8'hfd, 8'h00, 1, epc + 12'h001);
         run({5'b01101, a[10:8]}, a[7:0], 2, {epc[11] ^ i[0], a});
         n = $random(seed);
         ret = epc + 12'h001;
         run({4'hb, n}, 8'h00, 1, {6'h00, n, 2'h0});
         run(8'h62, 8'h00, 1, ret);
         ret = epc + 12'h002;
         run({5'b10101, a[10:8]}, a[7:0], 2, {1'b0, a});
         run(8'h62, 8'h00, 1, ret);
      end
      for (i = 0; i < 9; i++) begin
         if (i != 7) begin
            run(8'h2c, {4'h5, i[3:0]}, 2, epc + 12'h002);
            chk(ctl_all[i] === 1'b1, "ctl set");
            run(8'h2c, {4'h6, i[3:0]}, 2, epc + 12'h002);
            chk(ctl_all[i] === 1'b0 && (i != 8 || o_alu.zero === 1'b1), "ctl clear");
         end
      end
      run(8'h2c, 8'h58, 2, epc + 12'h002);
      cmp_imm(eacc);
      ret = epc;
      i_irq_req = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_irq_req = 1'b0;
      epc = 12'h008;
      chk(o_pc === epc && o_gate === 1'b0, "irq entry");
      cmp_imm(~eacc);
      run(8'h22, 8'h00, 1, ret);
      chk(o_alu.carry === 1'b1 && o_alu.zero === 1'b1, "irq return");
      for (i = 0; i < 6; i++) begin
         n = $random(seed);
         i_port_nibble = $random(seed);
         run({2'b00, n[2], 3'b001, n[1:0]}, 8'h00, 2, epc + 12'h001);
         k = i_port_nibble;
         k[n[1:0]] = ~n[2];
         chk(o_port_wr.wr === 1'b1 && o_port_wr.addr === edp && o_port_wr.data === k, "port");
         if (n[2]) chk(o_alu.zero === (k == 4'h0), "port zero");
      end
      for (i = 0; i < 4096; i++) begin
         pm.mem[i] = 8'h00;
      end
      run(8'h2c, 8'h58, 2, epc + 12'h002);
      i = 0;
      while (o_wdt_irq !== 1'b1 && i < 100) begin
         @(posedge i_ref_clk);
         #1;
         i++;
      end
      chk(o_wdt_irq === 1'b1 && o_ctl[7] === 1'b1, "watchdog");
      epc = o_pc;
      run(8'h2c, 8'h67, 2, epc + 12'h002);
      chk(o_ctl[7] === (edges % 17 == 0), "watchdog clear");
      finish_test();
   end
endmodule // nibble_cpu_instruction_decode_tb
bind ncid_core ncid_core_assertions #(.DIV_ONE(DIV_ONE)) chk_i (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_prog_byte(i_prog_byte), .i_irq_req(i_irq_req),
   .o_pc(o_pc), .o_dp(o_dp), .o_port_wr(o_port_wr), .o_alu(o_alu), .o_ctl(o_ctl),
   .o_gate(o_gate), .o_wdt_irq(o_wdt_irq));
